// ### hdl/keypad_irq_pkg.sv
// package: register map, field layout and carriers for the keypad irq unit
package keypad_irq_pkg;
  localparam int         PIN_COUNT      = 8;
  localparam int         ADDR_WIDTH     = 4;
  // register byte addresses on the wishbone bus
  localparam logic [3:0] STATUS_CTRL_ADDR = 4'h0;
  localparam logic [3:0] TRIG_EN_ADDR     = 4'h4;
  localparam logic [3:0] POLARITY_ADDR    = 4'h8;
  localparam logic [3:0] PULL_EN_ADDR     = 4'hC;
  // status/control field positions
  localparam int         MODE_BIT       = 0;
  localparam int         IRQ_EN_BIT     = 1;
  localparam int         ACK_BIT        = 2;
  localparam int         FLAG_BIT       = 3;
  // reset values
  localparam logic [7:0] BYTE_RESET     = 8'h00;
  localparam logic       BIT_RESET      = 1'b0;
  localparam logic [31:0] WORD_ZERO     = 32'h0000_0000;
  localparam logic [1:0] SYNC_RESET     = 2'h0;

  // settings shared between the bus slave and the detector
  typedef struct packed {
    logic [7:0] trig_en;
    logic [7:0] polarity;
    logic       level_mode;
  } detect_cfg_t;
endpackage : keypad_irq_pkg

// ### hdl/keypad_pin_sync.sv
// file: two-stage synchroniser for one keypad input
`timescale 1ns/1ps
module keypad_pin_sync (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic pin_async,
  output logic      pin_sync
);
  import keypad_irq_pkg::*;

  logic [1:0] stage_reg;

  // the first stage feeds only the second
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      stage_reg <= SYNC_RESET;
    end else begin
      stage_reg <= {stage_reg[0], pin_async};
    end
  end

  assign pin_sync = stage_reg[1];
endmodule : keypad_pin_sync

// ### hdl/keypad_irq_unit.sv
// file: keypad edge/level interrupt unit with wishbone register slave
//
// Local design decisions: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
// Operation
// - one enable bit per pin 7..0; 1 makes the pin a trigger source
// - one polarity bit per pin; 0 falling/low, 1 rising/high
// - a single mode setting applies to all enabled pins
// - mode 0 detects edges only, mode 1 edges and levels
// - falling edge is 1 then 0 on consecutive cycles
// - rising edge is 0 then 1 on consecutive cycles
// - after an edge, all enabled pins must deassert before the next
// - edge-only mode: a valid edge sets the event flag
// - edge-and-level mode: edge or asserted level sets the flag
// - interrupt request when flag set and interrupt enable is 1
// - writing 1 to acknowledge clears the event flag
// - level mode: ack clears only if all enabled pins deasserted
// - pad resistor pulls up for polarity 0, down for polarity 1
// - up to eight independent keypad inputs
// - flag reads 1 after an event; writes to it do nothing
// - ack bit and upper four status bits always read 0
// - interrupt enable 0 blocks the request, 1 allows it
module keypad_irq_unit (
  input  wire logic                                 core_clk,
  input  wire logic                                 rst_n,
  // classic wishbone slave
  input  wire logic                                 wb_cyc_i,
  input  wire logic                                 wb_stb_i,
  input  wire logic                                 wb_we_i,
  input  wire logic [keypad_irq_pkg::ADDR_WIDTH-1:0] wb_adr_i,
  input  wire logic [3:0]                           wb_sel_i,
  input  wire logic [31:0]                          wb_dat_i,
  output logic      [31:0]                          wb_dat_o,
  output logic                                      wb_ack_o,
  // keypad pins and pad control
  input  wire logic [keypad_irq_pkg::PIN_COUNT-1:0] keypad_input_pin,
  output logic      [keypad_irq_pkg::PIN_COUNT-1:0] pad_pull_on,
  output logic      [keypad_irq_pkg::PIN_COUNT-1:0] pad_pull_up,
  output logic                                      key_irq
);
  import keypad_irq_pkg::*;

  detect_cfg_t        cfg;
  logic [7:0]         trigger_enable_reg;
  logic [7:0]         polarity_select_reg;
  logic [7:0]         port_pull_enable_reg;
  logic               level_detect_mode_reg;
  logic               key_irq_enable_reg;
  logic               key_event_flag_reg;
  logic               armed_reg;
  logic               wb_ack_reg;
  logic [31:0]        rdata_reg;
  logic [PIN_COUNT-1:0] pin_sync;
  logic [PIN_COUNT-1:0] pin_prev_reg;
  logic [PIN_COUNT-1:0] asserted_now;
  logic [PIN_COUNT-1:0] asserted_prev;
  logic               any_asserted;
  logic               edge_seen;
  logic               level_seen;
  logic               event_set;
  logic               bus_req;
  logic               wr_req;
  logic               ack_write;
  logic               ack_clears;
  logic               sel_lo;
  logic [7:0]         status_byte;

  assign cfg.trig_en    = trigger_enable_reg;
  assign cfg.polarity   = polarity_select_reg;
  assign cfg.level_mode = level_detect_mode_reg;

  // synchronise every pin before any comparison
  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pin
      keypad_pin_sync u_sync (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .pin_async (keypad_input_pin[gi]),
        .pin_sync  (pin_sync[gi])
      );
      // polarity maps each pin to "asserted" only when enabled
      assign asserted_now[gi]  = cfg.trig_en[gi] &
                                 (pin_sync[gi] ~^ cfg.polarity[gi]);
      assign asserted_prev[gi] = cfg.trig_en[gi] &
                                 (pin_prev_reg[gi] ~^ cfg.polarity[gi]);
      // pad resistor direction follows polarity
      assign pad_pull_up[gi]   = ~cfg.polarity[gi];
    end
  endgenerate

  assign pad_pull_on = port_pull_enable_reg;

  // previous sample of the synchronised pins
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pin_prev_reg <= BYTE_RESET;
    end else begin
      pin_prev_reg <= pin_sync;
    end
  end

  // an edge is deasserted-then-asserted across consecutive cycles
  assign any_asserted = |asserted_now;
  assign edge_seen    = armed_reg &
                        (|(asserted_now & ~asserted_prev));
  assign level_seen   = cfg.level_mode & any_asserted;
  assign event_set    = edge_seen | level_seen;

  // arm only once every enabled pin reads deasserted
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      armed_reg <= BIT_RESET;
    end else if (!any_asserted) begin
      armed_reg <= 1'b1;
    end else if (edge_seen) begin
      armed_reg <= 1'b0;
    end
  end

  // bus decode; only the low byte lane carries register data
  assign bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_reg;
  assign wr_req    = bus_req & wb_we_i;
  assign sel_lo    = wb_sel_i[0];
  assign ack_write = wr_req & sel_lo & (wb_adr_i == STATUS_CTRL_ADDR) &
                     wb_dat_i[ACK_BIT];
  // in level mode an asserted pin keeps the flag through an ack
  assign ack_clears = ack_write & ~(cfg.level_mode & any_asserted);

  // event flag: a new event wins over a same-cycle acknowledge
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      key_event_flag_reg <= BIT_RESET;
    end else if (event_set) begin
      key_event_flag_reg <= 1'b1;
    end else if (ack_clears) begin
      key_event_flag_reg <= 1'b0;
    end
  end

  // status/control writable fields; the flag itself ignores writes
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      level_detect_mode_reg <= BIT_RESET;
      key_irq_enable_reg    <= BIT_RESET;
    end else if (wr_req && sel_lo && wb_adr_i == STATUS_CTRL_ADDR) begin
      level_detect_mode_reg <= wb_dat_i[MODE_BIT];
      key_irq_enable_reg    <= wb_dat_i[IRQ_EN_BIT];
    end
  end

  // pin enable, polarity and pull enable registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      trigger_enable_reg   <= BYTE_RESET;
      polarity_select_reg  <= BYTE_RESET;
      port_pull_enable_reg <= BYTE_RESET;
    end else if (wr_req && sel_lo) begin
      case (wb_adr_i)
        TRIG_EN_ADDR:  trigger_enable_reg   <= wb_dat_i[7:0];
        POLARITY_ADDR: polarity_select_reg  <= wb_dat_i[7:0];
        PULL_EN_ADDR:  port_pull_enable_reg <= wb_dat_i[7:0];
        default: ;
      endcase
    end
  end

  // ack and upper bits read as zero
  always_comb begin
    status_byte             = BYTE_RESET;
    status_byte[FLAG_BIT]   = key_event_flag_reg;
    status_byte[IRQ_EN_BIT] = key_irq_enable_reg;
    status_byte[MODE_BIT]   = level_detect_mode_reg;
  end

  // read data is registered with the ack; unmapped reads give zero
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rdata_reg <= WORD_ZERO;
    end else if (bus_req && !wb_we_i) begin
      case (wb_adr_i)
        STATUS_CTRL_ADDR: rdata_reg <= {24'h000000, status_byte};
        TRIG_EN_ADDR:     rdata_reg <= {24'h000000, trigger_enable_reg};
        POLARITY_ADDR:    rdata_reg <= {24'h000000, polarity_select_reg};
        PULL_EN_ADDR:     rdata_reg <= {24'h000000, port_pull_enable_reg};
        default:          rdata_reg <= WORD_ZERO;
      endcase
    end
  end

  // one-cycle ack, one edge after the request; never two in a row
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wb_ack_reg <= BIT_RESET;
    end else begin
      wb_ack_reg <= bus_req;
    end
  end

  assign wb_ack_o = wb_ack_reg;
  assign wb_dat_o = rdata_reg;
  // request gated by the interrupt enable
  assign key_irq  = key_event_flag_reg & key_irq_enable_reg;
endmodule : keypad_irq_unit

// ### verif/keypad_irq_unit_assertions.sv
// checker: port-level assertions for the keypad irq unit
`timescale 1ns/1ps
module keypad_irq_unit_checker
  import keypad_irq_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [7:0]  pad_pull_on,
  input wire logic [7:0]  pad_pull_up,
  input wire logic        key_irq
);
  logic       taken;
  logic       wr0;
  logic [7:0] pol_shadow;
  logic       ie_shadow;
  // a write lands at the edge where the request is taken
  assign taken = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr0   = taken && wb_we_i && wb_sel_i[0];
  // shadow of the polarity register
  always_ff @(posedge core_clk) begin
    if (!rst_n) pol_shadow <= BYTE_RESET;
    else if (wr0 && wb_adr_i == POLARITY_ADDR) pol_shadow <= wb_dat_i[7:0];
  end
  // shadow of the irq enable bit
  always_ff @(posedge core_clk) begin
    if (!rst_n) ie_shadow <= BIT_RESET;
    else if (wr0 && wb_adr_i == STATUS_CTRL_ADDR) ie_shadow <= wb_dat_i[1];
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_ack_answer: assert property (taken |=> wb_ack_o)
    else $error("request not acknowledged");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_pull_dir: assert property (pad_pull_up == ~pol_shadow)
    else $error("pull direction does not follow polarity");
  a_pull_on_write: assert property ((wr0 && wb_adr_i == PULL_EN_ADDR)
    |=> pad_pull_on == $past(wb_dat_i[7:0])) else $error("pull enable lost");
  a_irq_gate: assert property (!ie_shadow |-> !key_irq)
    else $error("irq raised while masked");
  a_status_zeros: assert property ((wb_ack_o && !$past(wb_we_i)
    && $past(wb_adr_i) == STATUS_CTRL_ADDR) |-> wb_dat_o[7:4] == 4'h0
    && !wb_dat_o[ACK_BIT]) else $error("status zero bits read set");
  a_flag_read: assert property ((wb_ack_o && !$past(wb_we_i)
    && $past(wb_adr_i) == STATUS_CTRL_ADDR && $past(key_irq))
    |-> wb_dat_o[FLAG_BIT]) else $error("flag reads clear during irq");
  a_reset_clear: assert property (disable iff (1'b0) !rst_n
    |=> !key_irq && !wb_ack_o && pad_pull_on == 8'h00)
    else $error("reset did not clear outputs");
endmodule : keypad_irq_unit_checker

bind keypad_irq_unit keypad_irq_unit_checker u_chk (.*);

// ### verif/keypad_switch_model.sv
// partner: key switches on pulled pads; a pressed key drives against the pull
`timescale 1ns/1ps
module keypad_switch_model (
  input  wire logic       core_clk,
  input  wire logic [7:0] press,
  input  wire logic [7:0] pull_on,
  input  wire logic [7:0] pull_up,
  output logic      [7:0] pins
);
  logic [7:0] float_q = 8'h00;
  // unpulled pads float, so they toggle rather than keep a stale level
  always @(posedge core_clk) float_q <= ~float_q;
  // pull up reads high at rest, pull down low; a press inverts it
  assign pins = (pull_on & (pull_up ^ press)) | (~pull_on & float_q);
endmodule : keypad_switch_model

// ### verif/keypad_irq_unit_bench.sv
// bench: self-checking testbench for the keypad irq unit
`timescale 1ns/1ps
module keypad_irq_unit_bench;
  import keypad_irq_pkg::*;
  logic        core_clk    = 1'b0;
  logic        rst_n       = 1'b0;
  logic        cyc         = 1'b0;
  logic        we          = 1'b0;
  logic [3:0]  adr         = 4'h0;
  logic [31:0] wdat        = 32'h0;
  logic [7:0]  press       = 8'h00;
  logic [7:0]  pol;
  logic [7:0]  pins;
  logic [7:0]  pull_on;
  logic [7:0]  pull_up;
  logic [31:0] rdat;
  logic        ack;
  logic        irq;
  logic [31:0] exp_q[$];
  int          num_errors  = 0;
  int          check_count = 0;
  keypad_irq_unit u_dut (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .keypad_input_pin(pins), .pad_pull_on(pull_on), .pad_pull_up(pull_up),
    .key_irq(irq));
  keypad_switch_model u_keys (.core_clk(core_clk), .press(press),
    .pull_on(pull_on), .pull_up(pull_up), .pins(pins));
  // 200 MHz clock
  initial forever #2.5 core_clk = ~core_clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run();
    if (num_errors == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  // one classic cycle; strobe shares cyc, held until ack is sampled
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n = 0;
    @(posedge core_clk);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do @(posedge core_clk); while (ack !== 1'b1 && ++n < 20);
    // a slave that never answers is a failure, not a silent release
    if (ack !== 1'b1) num_errors++;
    cyc <= 1'b0;
  endtask : bus
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    bus(1'b0, a, 8'h00);
  endtask : rd
  // flag is visible 3-4 edges after a pin change
  task automatic key(input logic [7:0] p, input logic e);
    @(posedge core_clk);
    press <= p;
    repeat (6) @(posedge core_clk);
    check({31'h0, irq}, {31'h0, e});
  endtask : key
  // read results are matched against the oldest expectation
  always @(posedge core_clk) begin
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
      check(rdat, exp_q.pop_front());
    end
  end
  // watchdog sized well above the scripted run
  initial begin
    repeat (5000) @(posedge core_clk);
    num_errors++;
    complete_run();
  end
  initial begin
    void'($urandom(32'h103C24CB));
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) rd(4'(i * 4), 8'h00);
    rd(4'h2, 8'h00);
    pol = 8'($urandom());
    bus(1'b1, POLARITY_ADDR, pol);
    bus(1'b1, PULL_EN_ADDR, 8'($urandom()));
    rd(POLARITY_ADDR, pol);
    check({24'h0, pull_up}, {24'h0, ~pol});
    // mask, polarity, pulls, enable pin 0, ack, unmask
    bus(1'b1, STATUS_CTRL_ADDR, 8'h00);
    bus(1'b1, POLARITY_ADDR, 8'h00);
    bus(1'b1, PULL_EN_ADDR, 8'hFF);
    bus(1'b1, TRIG_EN_ADDR, 8'h01);
    bus(1'b1, STATUS_CTRL_ADDR, 8'h04);
    bus(1'b1, STATUS_CTRL_ADDR, 8'h02);
    key(8'h02, 1'b0);
    key(8'h03, 1'b1);
    bus(1'b1, STATUS_CTRL_ADDR, 8'h0E);
    key(8'h03, 1'b0);
    key(8'h00, 1'b0);
    key(8'h01, 1'b1);
    bus(1'b1, STATUS_CTRL_ADDR, 8'h00);
    rd(STATUS_CTRL_ADDR, 8'h08);
    key(8'h01, 1'b0);
    // level mode: a held key survives the ack, a released one does not
    bus(1'b1, STATUS_CTRL_ADDR, 8'h07);
    key(8'h01, 1'b1);
    rd(STATUS_CTRL_ADDR, 8'h0B);
    key(8'h00, 1'b1);
    bus(1'b1, STATUS_CTRL_ADDR, 8'h07);
    key(8'h00, 1'b0);
    // rising polarity; a polarity swap can flag, so ack after it
    bus(1'b1, POLARITY_ADDR, 8'h01);
    repeat (6) @(posedge core_clk);
    bus(1'b1, STATUS_CTRL_ADDR, 8'h06);
    key(8'h00, 1'b0);
    key(8'h01, 1'b1);
    complete_run();
  end
endmodule : keypad_irq_unit_bench
